// file: spi_blk_pkg.sv
`default_nettype none
package spi_blk_pkg;
  // ************************************************************
  // Block format
  // ************************************************************
  localparam int BLOCK_BITS = 40;
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_WR_LO = 8'h01;
  localparam logic [7:0] CMD_WR_HI = 8'h02;
  localparam logic [7:0] STAT_NONE = 8'h00;
  localparam logic [7:0] STAT_WRITE_OK = 8'h01;
  localparam logic [7:0] STAT_WRITE_FAILED = 8'h02;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_PROTECTED = 16'h0001;
  localparam logic [15:0] ERR_NOT_ENABLED = 16'h0002;
  localparam logic [15:0] ERR_BAD_CMD = 16'h0003;
  localparam logic [15:0] ERR_SHORT_BLOCK = 16'h0004;
  // ************************************************************
  // Register areas (word addresses)
  // ************************************************************
  localparam logic [15:0] SYNC_IN_LO = 16'h1001;
  localparam logic [15:0] SYNC_OUT_LO = 16'h0C01;
  localparam logic [15:0] SYNC_OUT_HI = 16'h0D00;
  localparam logic [15:0] SDP_IN_LO = 16'h1401;
  localparam logic [15:0] SDP_IN_HI = 16'h1500;
  localparam logic [15:0] SDP_OUT_LO = 16'h1801;
  localparam logic [15:0] SDP_OUT_HI = 16'h1900;
  localparam logic [15:0] FB_IN_LO = 16'h2001;
  localparam logic [15:0] FB_IN_HI = 16'h2100;
  localparam logic [15:0] FB_OUT_LO = 16'h2801;
  localparam logic [15:0] FB_OUT_HI = 16'h2900;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_KHZ = 250_000;
  localparam int READY_MAX_MS = 10;
  localparam int READY_MAX_CYC = READY_MAX_MS * CLK_KHZ;
  localparam int SCLK_MAX_KHZ = 20_000;
  localparam int SCLK_HALF_CYC = (CLK_KHZ + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
  // ************************************************************
  // Controller registers (byte offsets)
  // ************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BLOCK = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_GO = 8'h0C;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam int CTRL_CPOL_BIT = 0;
  localparam int CTRL_CPHA_BIT = 1;
  localparam int RESULT_BUSY_BIT = 31;
  localparam int RESULT_TIMEOUT_BIT = 30;
  localparam logic [31:0] BLOCK_RESET = 32'h00000000;
  localparam logic [7:0] MASK_RESET = 8'h00;
endpackage
`default_nettype wire

// file: spi_blk_if.sv
`timescale 1ns/1ns
`default_nettype none
interface spi_blk_if;
  logic sclk;
  logic mosi;
  logic miso;
  logic cs;
  logic rdy;
  modport dev(input sclk, input mosi, input cs, output miso, output rdy);
  modport mst(output sclk, output mosi, output cs, input miso, input rdy);
endinterface
`default_nettype wire

// file: spi_blk_device.sv
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module spi_blk_device #(
  parameter int MEM_WORDS = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Link
  spi_blk_if.dev link,
  // Configuration
  input wire logic spiSlaveMode,
  input wire logic cpol,
  input wire logic cpha,
  // Sync input area read port
  input wire logic [$clog2(MEM_WORDS)-1:0] syncInIdx,
  output logic [15:0] syncInData,
  output logic validRestart,
  // Other register write port
  output logic extWrite,
  output logic [15:0] extAddr,
  output logic extLaneHigh,
  output logic [7:0] extData,
  output logic [7:0] extMask,
  input wire logic extEnabled
);
  import spi_blk_pkg::*;

  localparam int IDX_W = $clog2(MEM_WORDS);

  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [1:0] {S_IDLE, S_RX, S_PROC} dev_state_t;

  typedef struct packed {
    dev_state_t st;
    logic [2:0] sclkS;
    logic [2:0] mosiS;
    logic [2:0] csS;
    logic sclkF;
    logic mosiF;
    logic csF;
    logic [5:0] bitCnt;
    logic [39:0] rx;
    logic [39:0] tx;
    logic [15:0] blkAddr;
    logic rdy;
    logic validRestart;
    logic extWrite;
    logic extLaneHigh;
    logic [7:0] extData;
    logic [7:0] extMask;
    logic [MEM_WORDS-1:0][15:0] mem;
  } dev_regs_t;

  dev_regs_t state_reg;
  dev_regs_t state_next;

  // Writes into these areas are always refused
  function automatic logic isProtected(input logic [15:0] a);
    isProtected = (a >= SYNC_OUT_LO && a <= SYNC_OUT_HI) ||
                  (a >= SDP_IN_LO && a <= SDP_IN_HI) ||
                  (a >= SDP_OUT_LO && a <= SDP_OUT_HI) ||
                  (a >= FB_IN_LO && a <= FB_IN_HI) ||
                  (a >= FB_OUT_LO && a <= FB_OUT_HI);
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic edgeSeen;
    logic leadE;
    logic trailE;
    logic sampleE;
    logic shiftE;
    logic [7:0] cmd;
    logic [15:0] addr;
    logic [7:0] dat;
    logic [7:0] msk;
    logic [7:0] stat;
    logic [15:0] err;
    logic [IDX_W-1:0] idx;
    logic [15:0] word;
    edgeSeen = 1'b0;
    leadE = 1'b0;
    trailE = 1'b0;
    sampleE = 1'b0;
    shiftE = 1'b0;
    cmd = 8'h00;
    addr = 16'h0000;
    dat = 8'h00;
    msk = 8'h00;
    stat = STAT_NONE;
    err = ERR_NONE;
    idx = '0;
    word = 16'h0000;
    state_next = state_reg;
    state_next.validRestart = 1'b0;
    state_next.extWrite = 1'b0;

    // Three-stage synchronisers; a level is taken once stages two and three agree
    state_next.sclkS = {state_reg.sclkS[1:0], link.sclk};
    state_next.mosiS = {state_reg.mosiS[1:0], link.mosi};
    state_next.csS = {state_reg.csS[1:0], link.cs};
    if (state_reg.sclkS[1] == state_reg.sclkS[2]) state_next.sclkF = state_reg.sclkS[2];
    if (state_reg.mosiS[1] == state_reg.mosiS[2]) state_next.mosiF = state_reg.mosiS[2];
    if (state_reg.csS[1] == state_reg.csS[2]) state_next.csF = state_reg.csS[2];

    // Leading edge leaves the idle level; phase picks which edge samples
    edgeSeen = state_next.sclkF != state_reg.sclkF;
    leadE = edgeSeen && (state_next.sclkF != cpol);
    trailE = edgeSeen && (state_next.sclkF == cpol);
    sampleE = cpha ? trailE : leadE;
    shiftE = cpha ? leadE : trailE;

    case (state_reg.st)
      S_IDLE: begin
        state_next.rdy = 1'b0;
        // Accept at once: the reply is already loaded
        if (spiSlaveMode && state_reg.csF) begin
          state_next.st = S_RX;
          state_next.bitCnt = 6'h00;
          state_next.rdy = 1'b1;
        end
      end
      S_RX: begin
        if (!state_reg.csF) begin
          // Address latched now so the enable answer is settled next cycle
          state_next.blkAddr = state_reg.rx[31:16];
          state_next.st = S_PROC;
        end else begin
          // Only edges inside a selected block count
          if (sampleE && state_reg.bitCnt != 6'(BLOCK_BITS)) begin
            state_next.rx = {state_reg.rx[38:0], state_next.mosiF};
            state_next.bitCnt = state_reg.bitCnt + 6'h01;
          end
          // No shift before the first sample or after the last one
          if (shiftE && state_reg.bitCnt != 6'h00 &&
              state_reg.bitCnt != 6'(BLOCK_BITS)) begin
            state_next.tx = {state_reg.tx[38:0], 1'b0};
          end
        end
      end
      S_PROC: begin
        cmd = state_reg.rx[39:32];
        addr = state_reg.blkAddr;
        dat = state_reg.rx[15:8];
        msk = state_reg.rx[7:0];
        idx = IDX_W'(addr - SYNC_IN_LO);
        word = state_reg.mem[idx];
        if (state_reg.bitCnt != 6'(BLOCK_BITS)) begin
          stat = STAT_WRITE_FAILED;
          err = ERR_SHORT_BLOCK;
        end else if (cmd == CMD_NOP) begin
          stat = STAT_NONE;
        end else if (cmd != CMD_WR_LO && cmd != CMD_WR_HI) begin
          stat = STAT_WRITE_FAILED;
          err = ERR_BAD_CMD;
        end else if (isProtected(addr)) begin
          stat = STAT_WRITE_FAILED;
          err = ERR_PROTECTED;
        end else if (addr >= SYNC_IN_LO && addr < SYNC_IN_LO + MEM_WORDS) begin
          // Read-modify-write keeps unmasked bits
          if (cmd == CMD_WR_HI) begin
            word[15:8] = (word[15:8] & ~msk) | (dat & msk);
          end else begin
            word[7:0] = (word[7:0] & ~msk) | (dat & msk);
          end
          state_next.mem[idx] = word;
          state_next.validRestart = 1'b1;
          stat = STAT_WRITE_OK;
        end else if (extEnabled) begin
          // Owner of the register applies the mask the same way
          state_next.extWrite = 1'b1;
          state_next.extLaneHigh = cmd == CMD_WR_HI;
          state_next.extData = dat;
          state_next.extMask = msk;
          stat = STAT_WRITE_OK;
        end else begin
          stat = STAT_WRITE_FAILED;
          err = ERR_NOT_ENABLED;
        end
        // Reply for the next block, loaded in the same cycle that ready drops
        state_next.tx = {stat, err, 16'h0000};
        state_next.rdy = 1'b0;
        state_next.st = S_IDLE;
      end
      default: begin
        state_next.st = S_IDLE;
        state_next.rdy = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= '0;
      state_reg.st <= S_IDLE;
      state_reg.tx <= {STAT_NONE, ERR_NONE, 16'h0000};
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign link.miso = state_reg.tx[39];
  assign link.rdy = state_reg.rdy;
  assign syncInData = state_reg.mem[syncInIdx];
  assign validRestart = state_reg.validRestart;
  assign extWrite = state_reg.extWrite;
  assign extAddr = state_reg.blkAddr;
  assign extLaneHigh = state_reg.extLaneHigh;
  assign extData = state_reg.extData;
  assign extMask = state_reg.extMask;
endmodule
`default_nettype wire

// file: spi_blk_master.sv
`timescale 1ns/1ns
`default_nettype none
module spi_blk_master #(
  parameter int HALF_CYC = spi_blk_pkg::SCLK_HALF_CYC,
  parameter int READY_TIMEOUT_CYC = spi_blk_pkg::READY_MAX_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Link
  spi_blk_if.mst link
);
  import spi_blk_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [2:0] {M_IDLE, M_WLOW, M_WHIGH, M_SHIFT, M_END} mst_state_t;

  typedef struct packed {
    mst_state_t st;
    logic wrPend;
    logic [7:0] wrAddr;
    logic [31:0] rdData;
    logic cpol;
    logic cpha;
    logic [31:0] block;
    logic [7:0] mask;
    logic timeout;
    logic [39:0] tx;
    logic [39:0] rx;
    logic [2:0] rdyS;
    logic [2:0] misoS;
    logic rdyF;
    logic misoF;
    logic [15:0] halfCnt;
    logic half;
    logic [5:0] bitCnt;
    logic [31:0] toCnt;
    logic sclk;
    logic mosi;
    logic cs;
  } mst_regs_t;

  mst_regs_t state_reg;
  mst_regs_t state_next;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic busy;
    logic halfDone;
    busy = state_reg.st != M_IDLE;
    halfDone = state_reg.halfCnt == 16'(HALF_CYC - 1);
    state_next = state_reg;
    state_next.rdyS = {state_reg.rdyS[1:0], link.rdy};
    state_next.misoS = {state_reg.misoS[1:0], link.miso};
    if (state_reg.rdyS[1] == state_reg.rdyS[2]) state_next.rdyF = state_reg.rdyS[2];
    if (state_reg.misoS[1] == state_reg.misoS[2]) state_next.misoF = state_reg.misoS[2];

    // Data phase of the previous write; a GO while busy is dropped
    state_next.wrPend = 1'b0;
    if (state_reg.wrPend) begin
      case (state_reg.wrAddr)
        OFS_CTRL: begin
          state_next.cpol = hwdata[CTRL_CPOL_BIT];
          state_next.cpha = hwdata[CTRL_CPHA_BIT];
        end
        OFS_BLOCK: state_next.block = hwdata;
        OFS_MASK: state_next.mask = hwdata[7:0];
        OFS_GO: begin
          if (!busy) begin
            state_next.st = M_WLOW;
            state_next.tx = {state_reg.block, state_reg.mask};
            state_next.timeout = 1'b0;
            state_next.sclk = state_reg.cpol;
          end
        end
        default: begin
        end
      endcase
    end

    // Address phase; read data is registered for the data phase
    if (hsel && hready && htrans[1]) begin
      state_next.wrPend = hwrite;
      state_next.wrAddr = haddr[7:0];
      case (haddr[7:0])
        OFS_CTRL: state_next.rdData = {30'h0, state_reg.cpha, state_reg.cpol};
        OFS_BLOCK: state_next.rdData = state_reg.block;
        OFS_MASK: state_next.rdData = {24'h0, state_reg.mask};
        OFS_RESULT: state_next.rdData = {busy, state_reg.timeout, 6'h00, state_reg.rx[39:16]};
        default: state_next.rdData = 32'h00000000;
      endcase
    end

    case (state_reg.st)
      M_IDLE: begin
      end
      M_WLOW: begin
        if (!state_reg.rdyF) begin
          state_next.cs = 1'b1;
          state_next.toCnt = 32'h0;
          state_next.st = M_WHIGH;
        end
      end
      M_WHIGH: begin
        if (state_reg.rdyF) begin
          state_next.st = M_SHIFT;
          state_next.halfCnt = 16'h0;
          state_next.half = 1'b0;
          state_next.bitCnt = 6'h00;
          state_next.mosi = state_reg.tx[39];
          state_next.sclk = state_reg.cpol ^ state_reg.cpha;
        end else if (state_reg.toCnt == 32'(READY_TIMEOUT_CYC - 1)) begin
          state_next.timeout = 1'b1;
          state_next.cs = 1'b0;
          state_next.st = M_IDLE;
        end else begin
          state_next.toCnt = state_reg.toCnt + 32'h1;
        end
      end
      M_SHIFT: begin
        // Divider paces the clock; bits run with no gap
        state_next.halfCnt = state_reg.halfCnt + 16'h1;
        if (halfDone) begin
          state_next.halfCnt = 16'h0;
          if (!state_reg.half) begin
            state_next.half = 1'b1;
            state_next.sclk = state_reg.cpol ^ ~state_reg.cpha;
          end else begin
            // Late sample leaves room for both synchroniser delays
            state_next.rx = {state_reg.rx[38:0], state_reg.misoF};
            state_next.half = 1'b0;
            state_next.bitCnt = state_reg.bitCnt + 6'h01;
            if (state_reg.bitCnt == 6'(BLOCK_BITS - 1)) begin
              state_next.sclk = state_reg.cpol;
              state_next.st = M_END;
            end else begin
              state_next.tx = {state_reg.tx[38:0], 1'b0};
              state_next.mosi = state_reg.tx[38];
              state_next.sclk = state_reg.cpol ^ state_reg.cpha;
            end
          end
        end
      end
      M_END: begin
        state_next.halfCnt = state_reg.halfCnt + 16'h1;
        if (halfDone) begin
          state_next.cs = 1'b0;
          state_next.st = M_IDLE;
        end
      end
      default: state_next.st = M_IDLE;
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= '0;
      state_reg.st <= M_IDLE;
      state_reg.block <= BLOCK_RESET;
      state_reg.mask <= MASK_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = state_reg.rdData;
  assign link.sclk = state_reg.sclk;
  assign link.mosi = state_reg.mosi;
  assign link.cs = state_reg.cs;
endmodule
`default_nettype wire

// file: spi_blk_properties.sv
`timescale 1ns/1ns
`default_nettype none
module spi_blk_properties #(
  parameter int HALF_CYC = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Link signals
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic cs,
  input wire logic rdy,
  // Device mode; ready duties only apply in slave mode
  input wire logic slaveMode
);
  // ****************************************
  // Helper counters
  // ****************************************
  logic sclkPrev_reg;
  logic [7:0] edgeCount_reg;
  logic [7:0] gapCount_reg;

  // Edges in a block and cycles since last edge; counters avoid long repetitions
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sclkPrev_reg <= 1'b0;
      edgeCount_reg <= 8'h00;
      gapCount_reg <= 8'hFF;
    end else begin
      sclkPrev_reg <= sclk;
      if (!cs) begin
        edgeCount_reg <= 8'h00;
      end else if (sclk != sclkPrev_reg) begin
        edgeCount_reg <= edgeCount_reg + 8'h01;
      end
      if (sclk != sclkPrev_reg) begin
        gapCount_reg <= 8'h00;
      end else if (gapCount_reg != 8'hFF) begin
        gapCount_reg <= gapCount_reg + 8'h01;
      end
    end
  end

  // ****************************************
  // Handshake and framing
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_selectWhileIdle;
    $rose(cs) |-> !rdy;
  endproperty
  a_selectWhileIdle: assert property (p_selectWhileIdle)
    else $error("select raised while ready high");

  property p_readyRises;
    $rose(cs) && slaveMode |-> ##[1:16] rdy;
  endproperty
  a_readyRises: assert property (p_readyRises)
    else $error("ready did not follow select");

  property p_readyOnlyInBlock;
    $rose(rdy) |-> cs;
  endproperty
  a_readyOnlyInBlock: assert property (p_readyOnlyInBlock)
    else $error("ready rose without select");

  property p_noClockBeforeReady;
    cs && !rdy |-> $stable(sclk);
  endproperty
  a_noClockBeforeReady: assert property (p_noClockBeforeReady)
    else $error("serial clock moved before ready");

  property p_readyFallsAfterEnd;
    $fell(cs) && rdy |-> rdy [*2] ##[1:16] !rdy;
  endproperty
  a_readyFallsAfterEnd: assert property (p_readyFallsAfterEnd)
    else $error("ready did not fall in time after select");

  // Half period of HALF_CYC clocks keeps the link under its top rate
  property p_clockPacing;
    $changed(sclk) |-> gapCount_reg >= 8'(HALF_CYC - 2);
  endproperty
  a_clockPacing: assert property (p_clockPacing)
    else $error("serial clock edges too close");

  property p_fortyBits;
    $fell(cs) && slaveMode |-> edgeCount_reg == 8'h50;
  endproperty
  a_fortyBits: assert property (p_fortyBits)
    else $error("block did not hold forty bits");

  property p_idleOutputHeld;
    (!cs && !rdy) ##1 (!cs && !rdy) |-> $stable(miso);
  endproperty
  a_idleOutputHeld: assert property (p_idleOutputHeld)
    else $error("device output moved while deselected");
endmodule
`default_nettype wire

// file: spi_blk_tb.sv
`timescale 1ns/1ns
`default_nettype none
module spi_blk_tb;
  import spi_blk_pkg::*;
  localparam int HALF = 7;
  logic clk, reset_n, hsel, hwrite, hreadyout, hresp, cpol, cpha, extEnabled;
  logic validRestart, extWrite, extLaneHigh, csPrev, sclkPrev, slaveMode;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] syncInIdx;
  logic [7:0] extData, extMask;
  logic [15:0] syncInData, extAddr;
  logic [23:0] lastResult;
  logic [31:0] haddr, hwdata, hrdata, res;
  logic [39:0] mosiCap, misoCap;
  int bad_count, comparisons, cycles, bitCount, restarts, extWrites;

  spi_blk_if spi_blk_if_i();
  spi_blk_master #(.HALF_CYC(HALF), .READY_TIMEOUT_CYC(200)) spi_blk_master_i (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(spi_blk_if_i.mst));
  spi_blk_device #(.MEM_WORDS(16)) spi_blk_device_i (
    .clk(clk), .reset_n(reset_n), .link(spi_blk_if_i.dev), .spiSlaveMode(slaveMode),
    .cpol(cpol), .cpha(cpha), .syncInIdx(syncInIdx), .syncInData(syncInData),
    .validRestart(validRestart), .extWrite(extWrite), .extAddr(extAddr),
    .extLaneHigh(extLaneHigh), .extData(extData), .extMask(extMask), .extEnabled(extEnabled));
  spi_blk_properties #(.HALF_CYC(HALF)) spi_blk_properties_i (
    .clk(clk), .reset_n(reset_n), .sclk(spi_blk_if_i.sclk), .mosi(spi_blk_if_i.mosi),
    .miso(spi_blk_if_i.miso), .cs(spi_blk_if_i.cs), .rdy(spi_blk_if_i.rdy),
    .slaveMode(slaveMode));

  // ****************************************
  // Clock, wire monitor and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Sampling edge is rising when polarity equals phase, falling otherwise
  always @(posedge clk) begin
    csPrev <= spi_blk_if_i.cs;
    sclkPrev <= spi_blk_if_i.sclk;
    cycles <= cycles + 1;
    if (validRestart === 1'b1) restarts <= restarts + 1;
    if (extWrite === 1'b1) extWrites <= extWrites + 1;
    if (spi_blk_if_i.cs === 1'b1 && csPrev !== 1'b1) begin
      bitCount <= 0;
    end else if (spi_blk_if_i.cs === 1'b1 && spi_blk_if_i.sclk !== sclkPrev &&
                 spi_blk_if_i.sclk === (cpol == cpha)) begin
      bitCount <= bitCount + 1;
      mosiCap <= {mosiCap[38:0], spi_blk_if_i.mosi};
      misoCap <= {misoCap[38:0], spi_blk_if_i.miso};
    end
    if (cycles == 30000) begin
      $display("BAD %0t watchdog expired", $time);
      bad_count = bad_count + 1;
      complete_run();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Single word transfer; read data lands in res at the data phase edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    res = hrdata;
  endtask

  task automatic setMode(input logic [1:0] md);
    ahb(1'b1, OFS_CTRL, {30'h00000000, md});
    cpol <= md[0];
    cpha <= md[1];
  endtask

  // One block end to end; the reply carries the outcome of the block before
  task automatic blk(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d,
                     input logic [7:0] m, input logic [23:0] next);
    ahb(1'b1, OFS_BLOCK, {c, a, d});
    ahb(1'b1, OFS_MASK, {24'h000000, m});
    ahb(1'b1, OFS_GO, 32'h00000000);
    ahb(1'b0, OFS_RESULT, 32'h00000000);
    while (res[31] !== 1'b0) ahb(1'b0, OFS_RESULT, 32'h00000000);
    while (spi_blk_if_i.rdy !== 1'b0) @(posedge clk);
    @(posedge clk);
    chk(40'(bitCount), 40'h0000000028, "bit count");
    chk(mosiCap, {c, a, d, m}, "mosi block");
    chk(misoCap, {lastResult, 16'h0000}, "miso reply");
    chk(40'(res[23:0]), 40'(lastResult), "result register");
    lastResult = next;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_masked_bytes;
    syncInIdx <= 4'h0;
    blk(CMD_WR_LO, SYNC_IN_LO, 8'hA5, 8'h0F, {STAT_WRITE_OK, ERR_NONE});
    chk(40'(syncInData), 40'h0000000005, "low byte");
    chk(40'(restarts), 40'h0000000001, "restart pulse");
    blk(CMD_WR_HI, SYNC_IN_LO, 8'h3C, 8'hF0, {STAT_WRITE_OK, ERR_NONE});
    chk(40'(syncInData), 40'h0000003005, "high byte");
    blk(CMD_WR_LO, SYNC_IN_LO, 8'h5A, 8'hF0, {STAT_WRITE_OK, ERR_NONE});
    chk(40'(syncInData), 40'h0000003055, "low byte kept bits");
    $display("test_masked_bytes done");
  endtask

  // Every clock mode, writing the last word of the input area
  task automatic test_modes;
    syncInIdx <= 4'hF;
    for (int i = 0; i < 4; i++) begin
      setMode(2'(i));
      blk(CMD_WR_LO, SYNC_IN_LO + 16'h000F, 8'(8'hC0 + i), 8'hFF, {STAT_WRITE_OK, ERR_NONE});
      chk(40'(syncInData), 40'(16'h00C0 + i), "mode write");
    end
    setMode(2'h0);
    $display("test_modes done");
  endtask

  // Range ends of the read-only areas, with the user port willing
  task automatic test_protected;
    logic [15:0] prot [5];
    prot = '{SYNC_OUT_HI, 16'h1401, 16'h1900, FB_IN_LO, FB_OUT_HI};
    extEnabled <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      blk(CMD_WR_LO, prot[i], 8'hFF, 8'hFF, {STAT_WRITE_FAILED, ERR_PROTECTED});
    end
    chk(40'(extWrites), 40'h0000000000, "no user write");
    $display("test_protected done");
  endtask

  // First word past the input area goes out to the user port
  task automatic test_user_port;
    blk(CMD_WR_HI, SYNC_IN_LO + 16'h0010, 8'h81, 8'hC3, {STAT_WRITE_OK, ERR_NONE});
    chk(40'(extWrites), 40'h0000000001, "user write");
    chk({extAddr, 7'h00, extLaneHigh, extData, extMask}, 40'h10110181C3, "user port");
    extEnabled <= 1'b0;
    blk(CMD_WR_LO, 16'h3000, 8'h11, 8'hFF, {STAT_WRITE_FAILED, ERR_NOT_ENABLED});
    chk(40'(extWrites), 40'h0000000001, "refused user write");
    $display("test_user_port done");
  endtask

  // Slave mode off: no ready comes, so the master gives up with a timeout
  task automatic test_slave_off;
    slaveMode <= 1'b0;
    ahb(1'b1, OFS_GO, 32'h00000000);
    ahb(1'b0, OFS_RESULT, 32'h00000000);
    while (res[31] !== 1'b0) ahb(1'b0, OFS_RESULT, 32'h00000000);
    chk(40'(res[31:30]), 40'h0000000001, "timeout flag");
    chk(40'(spi_blk_if_i.rdy), 40'h0000000000, "ready held low");
    // Let the dropped select settle through the synchroniser first
    repeat (8) @(posedge clk);
    slaveMode <= 1'b1;
    $display("test_slave_off done");
  endtask

  // Unknown command, then two idle blocks to collect status
  task automatic test_idle_blocks;
    blk(8'h07, 16'h3000, 8'h00, 8'h00, {STAT_WRITE_FAILED, ERR_BAD_CMD});
    blk(CMD_NOP, 16'h0000, 8'h00, 8'h00, {STAT_NONE, ERR_NONE});
    blk(CMD_NOP, 16'h0000, 8'h00, 8'h00, {STAT_NONE, ERR_NONE});
    $display("test_idle_blocks done");
  endtask

  task automatic complete_run;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    cpol = 1'b0;
    cpha = 1'b0;
    extEnabled = 1'b0;
    slaveMode = 1'b1;
    syncInIdx = 4'h0;
    {csPrev, sclkPrev, mosiCap, misoCap, lastResult, res} = '0;
    {bad_count, comparisons, cycles, bitCount, restarts, extWrites} = '0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    test_masked_bytes();
    test_modes();
    test_protected();
    test_user_port();
    test_slave_off();
    test_idle_blocks();
    complete_run();
  end
endmodule
`default_nettype wire
